/* File: rtl/txp_irq_ctrl.sv */
// What this block does
// - enables 19:16, continuity buf0-3, drive summary one
// - enables 15:12, header buf0-3, drive summary zero
// - enables 11:8, flush buf4-7, drive summary zero
// - enables 7:4, continuity buf4-7, drive summary zero
// - enables 3:0, header buf4-7, drive summary zero
// - disabled bit never affects summary one
// - disabled bit never affects summary zero
// - continuity error sets status; read clears it
// - header error sets status; read clears it
// - flush status set only while flush allowed
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module txp_irq_ctrl #(
	parameter int ADDR_W = 12
) (
	input  wire logic              aclk,                // system clock, 100 MHz
	input  wire logic              aresetn,             // sync reset, active low
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,        // write address
	input  wire logic              s_axi_awvalid,       // write address valid
	output var  logic              s_axi_awready,       // write address ready
	input  wire logic [31:0]       s_axi_wdata,         // write data
	input  wire logic [3:0]        s_axi_wstrb,         // write byte strobes
	input  wire logic              s_axi_wvalid,        // write data valid
	output var  logic              s_axi_wready,        // write data ready
	output var  logic [1:0]        s_axi_bresp,         // write response
	output var  logic              s_axi_bvalid,        // write response valid
	input  wire logic              s_axi_bready,        // write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,        // read address
	input  wire logic              s_axi_arvalid,       // read address valid
	output var  logic              s_axi_arready,       // read address ready
	output var  logic [31:0]       s_axi_rdata,         // read data
	output var  logic [1:0]        s_axi_rresp,         // read response
	output var  logic              s_axi_rvalid,        // read data valid
	input  wire logic              s_axi_rready,        // read data ready
	// error events from the transmit data path
	input  wire logic [7:0]        continuity_err_evt,  // per buffer 0..7, one-cycle pulse
	input  wire logic [7:0]        header_err_evt,      // per buffer 0..7, one-cycle pulse
	input  wire logic [3:0]        flush_err_evt,       // buffers 4..7 flushed on error
	// summary toward the system interrupt register
	output var  logic              summary_irq_tx_one,  // continuity group 0..3
	output var  logic              summary_irq_tx_zero, // all other sources
	output var  logic              irq                  // level, any summary set
);

	localparam int W = txp_pkg::STAT_W;
	localparam int G = txp_pkg::BUF_PER_GROUP;

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	generate
		if (ADDR_W < txp_pkg::MIN_ADDR_W || ADDR_W > 32) begin : g_bad_addr
			$error("txp_irq_ctrl: ADDR_W must be 12 to 32");
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	txp_pkg::txp_wr_e    wr_q;
	txp_pkg::txp_rd_e    rd_q;
	logic                aw_have_q;
	logic                w_have_q;
	logic [ADDR_W-1:0]   awaddr_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;
	logic [W-1:0]        enable_q;
	logic [G-1:0]        flush_allow_q;
	logic                wr_commit;
	logic                rd_take;
	logic [W-1:0]        set_vec;
	logic [W-1:0]        clr_vec;
	logic [W-1:0]        pending;
	logic [31:0]         rd_word;
	logic                rd_hit;

	txp_irq_if #(.N(W)) irq_bits_if ();

	txp_irq_bits #(
		.N       (W)
	) u_bits (
		.aclk    (aclk),
		.aresetn (aresetn),
		.bits    (irq_bits_if.owner)
	);

	// ----------------------------------------------------------------
	// address match
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
		hit = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(off));
	endfunction : hit

	// ----------------------------------------------------------------
	// event routing onto status positions
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < G; i++) begin : g_route
			assign set_vec[txp_pkg::CONT_LO_TOP - i]  = continuity_err_evt[i];
			assign set_vec[txp_pkg::HDR_LO_TOP - i]   = header_err_evt[i];
			assign set_vec[txp_pkg::FLUSH_HI_TOP - i] = flush_err_evt[i]
			                                            & flush_allow_q[i];
			assign set_vec[txp_pkg::CONT_HI_TOP - i]  = continuity_err_evt[G + i];
			assign set_vec[txp_pkg::HDR_HI_TOP - i]   = header_err_evt[G + i];
		end
	endgenerate

	assign irq_bits_if.set = set_vec;
	assign irq_bits_if.clr = clr_vec;

	// ----------------------------------------------------------------
	// status clear: read clears, write of one clears
	// ----------------------------------------------------------------
	always_comb begin
		clr_vec = '0;
		if (rd_take && hit(s_axi_araddr, txp_pkg::OFF_STATUS)) begin
			clr_vec = '1;
		end
		if (wr_commit && hit(awaddr_q, txp_pkg::OFF_STATUS)) begin
			for (int k = 0; k < W; k++) begin
				if (wstrb_q[k / 8]) begin
					clr_vec[k] = clr_vec[k] | wdata_q[k];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// write channel
	// ----------------------------------------------------------------
	assign wr_commit = (wr_q == txp_pkg::WR_COLLECT) && aw_have_q && w_have_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_q          <= txp_pkg::WR_COLLECT;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb_q       <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= txp_pkg::RESP_OKAY;
		end else begin
			case (wr_q)
				txp_pkg::WR_COLLECT: begin
					s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
					s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
					if (s_axi_awvalid && s_axi_awready) begin
						aw_have_q <= 1'b1;
						awaddr_q  <= s_axi_awaddr;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_have_q <= 1'b1;
						wdata_q  <= s_axi_wdata;
						wstrb_q  <= s_axi_wstrb;
					end
					if (wr_commit) begin
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= (hit(awaddr_q, txp_pkg::OFF_STATUS)
						                || hit(awaddr_q, txp_pkg::OFF_ENABLE)
						                || hit(awaddr_q, txp_pkg::OFF_FLUSH_ALLOW)
						                || hit(awaddr_q, txp_pkg::OFF_SUMMARY))
						                ? txp_pkg::RESP_OKAY : txp_pkg::RESP_SLVERR;
						wr_q         <= txp_pkg::WR_RESP;
					end
				end
				txp_pkg::WR_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid  <= 1'b0;
						aw_have_q     <= 1'b0;
						w_have_q      <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready  <= 1'b1;
						wr_q          <= txp_pkg::WR_COLLECT;
					end
				end
				default: wr_q <= txp_pkg::WR_COLLECT;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// enable register, bits above 19 read as zero
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_q <= txp_pkg::RST_ENABLE;
		end else if (wr_commit && hit(awaddr_q, txp_pkg::OFF_ENABLE)) begin
			for (int k = 0; k < W; k++) begin
				if (wstrb_q[k / 8]) begin
					enable_q[k] <= wdata_q[k];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// flush allow, one bit per buffer 4..7
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flush_allow_q <= txp_pkg::RST_FLUSH_ALLOW;
		end else if (wr_commit && hit(awaddr_q, txp_pkg::OFF_FLUSH_ALLOW) && wstrb_q[0]) begin
			flush_allow_q <= wdata_q[G-1:0];
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	assign rd_take = (rd_q == txp_pkg::RD_IDLE) && s_axi_arvalid && s_axi_arready;

	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		if (hit(s_axi_araddr, txp_pkg::OFF_STATUS)) begin
			rd_word[W-1:0] = irq_bits_if.status;
		end else if (hit(s_axi_araddr, txp_pkg::OFF_ENABLE)) begin
			rd_word[W-1:0] = enable_q;
		end else if (hit(s_axi_araddr, txp_pkg::OFF_FLUSH_ALLOW)) begin
			rd_word[G-1:0] = flush_allow_q;
		end else if (hit(s_axi_araddr, txp_pkg::OFF_SUMMARY)) begin
			rd_word[txp_pkg::SUM_ZERO_POS] = summary_irq_tx_zero;
			rd_word[txp_pkg::SUM_ONE_POS]  = summary_irq_tx_one;
			rd_word[txp_pkg::SUM_IRQ_POS]  = irq;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_q          <= txp_pkg::RD_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= txp_pkg::RESP_OKAY;
		end else begin
			case (rd_q)
				txp_pkg::RD_IDLE: begin
					s_axi_arready <= 1'b1;
					if (rd_take) begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rdata   <= rd_word;
						s_axi_rresp   <= rd_hit ? txp_pkg::RESP_OKAY : txp_pkg::RESP_SLVERR;
						rd_q          <= txp_pkg::RD_RESP;
					end
				end
				txp_pkg::RD_RESP: begin
					if (s_axi_rready) begin
						s_axi_rvalid  <= 1'b0;
						s_axi_arready <= 1'b1;
						rd_q          <= txp_pkg::RD_IDLE;
					end
				end
				default: rd_q <= txp_pkg::RD_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// summary outputs
	// ----------------------------------------------------------------
	assign pending = irq_bits_if.status & enable_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			summary_irq_tx_one  <= 1'b0;
			summary_irq_tx_zero <= 1'b0;
			irq                 <= 1'b0;
		end else begin
			summary_irq_tx_one  <= |pending[W-1:txp_pkg::ONE_GROUP_LSB];
			summary_irq_tx_zero <= |pending[txp_pkg::ONE_GROUP_LSB-1:0];
			irq                 <= |pending;
		end
	end

endmodule : txp_irq_ctrl

`default_nettype wire

/* File: pkg/txp_pkg.sv */
package txp_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_STATUS      = 12'h248;
	localparam logic [11:0] OFF_ENABLE      = 12'h24c;
	localparam logic [11:0] OFF_FLUSH_ALLOW = 12'h300;
	localparam logic [11:0] OFF_SUMMARY     = 12'h304;
	localparam int          MIN_ADDR_W      = 12;

	// ----------------------------------------------------------------
	// field layout of status and enable (same layout)
	// ----------------------------------------------------------------
	localparam int STAT_W        = 20;
	localparam int BUF_PER_GROUP = 4;
	localparam int CONT_LO_TOP   = 19;
	localparam int HDR_LO_TOP    = 15;
	localparam int FLUSH_HI_TOP  = 11;
	localparam int CONT_HI_TOP   = 7;
	localparam int HDR_HI_TOP    = 3;
	localparam int ONE_GROUP_LSB = 16;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [STAT_W-1:0]        RST_STATUS      = 20'h00000;
	localparam logic [STAT_W-1:0]        RST_ENABLE      = 20'h00000;
	localparam logic [BUF_PER_GROUP-1:0] RST_FLUSH_ALLOW = 4'h0;

	// ----------------------------------------------------------------
	// summary register bits
	// ----------------------------------------------------------------
	localparam int SUM_ZERO_POS = 0;
	localparam int SUM_ONE_POS  = 1;
	localparam int SUM_IRQ_POS  = 2;

	// ----------------------------------------------------------------
	// bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {WR_COLLECT, WR_RESP} txp_wr_e;
	typedef enum {RD_IDLE, RD_RESP} txp_rd_e;

endpackage : txp_pkg

/* File: pkg/txp_irq_if.sv */
`timescale 1ns/1ps
`default_nettype none

// set and clear requests toward the sticky status bits, status back
interface txp_irq_if #(
	parameter int N = 20
);
	logic [N-1:0] set;
	logic [N-1:0] clr;
	logic [N-1:0] status;

	modport owner (input set, input clr, output status);
	modport user  (output set, output clr, input status);
endinterface : txp_irq_if

`default_nettype wire

/* File: rtl/txp_irq_bits.sv */
`timescale 1ns/1ps
`default_nettype none

module txp_irq_bits #(
	parameter int N = 20
) (
	input  wire logic  aclk,     // system clock
	input  wire logic  aresetn,  // sync reset, active low
	txp_irq_if.owner   bits      // set, clear, status
);

	// ----------------------------------------------------------------
	// one sticky flag per source
	// ----------------------------------------------------------------
	generate
		if (N < 1) begin : g_bad_n
			$error("txp_irq_bits: N must be at least 1");
		end
		for (genvar i = 0; i < N; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					bits.status[i] <= 1'b0;
				end else if (bits.set[i]) begin
					// set wins over a clear in the same cycle
					bits.status[i] <= 1'b1;
				end else if (bits.clr[i]) begin
					bits.status[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule : txp_irq_bits

`default_nettype wire

/* File: tb/txp_irq_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none

module txp_irq_ctrl_props (
	input wire logic        aclk,                // clock
	input wire logic        aresetn,             // reset
	input wire logic        s_axi_awvalid,       // aw
	input wire logic        s_axi_awready,       // aw
	input wire logic        s_axi_wvalid,        // w
	input wire logic        s_axi_wready,        // w
	input wire logic [1:0]  s_axi_bresp,         // b
	input wire logic        s_axi_bvalid,        // b
	input wire logic        s_axi_bready,        // b
	input wire logic        s_axi_arvalid,       // ar
	input wire logic        s_axi_arready,       // ar
	input wire logic [31:0] s_axi_rdata,         // r
	input wire logic        s_axi_rvalid,        // r
	input wire logic        s_axi_rready,        // r
	input wire logic [7:0]  continuity_err_evt,  // events
	input wire logic        summary_irq_tx_one,  // summary
	input wire logic        summary_irq_tx_zero, // summary
	input wire logic        irq                  // level
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------------------------------------------------------------
	// bus handshakes
	// ----------------------------------------------------------------
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	a_wr_answer: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write response late");
	a_rd_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_reset_quiet: assert property ($past(!aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
		else $error("outputs active after reset");

	// ----------------------------------------------------------------
	// summary outputs
	// ----------------------------------------------------------------
	a_irq_is_or: assert property (irq == (summary_irq_tx_one || summary_irq_tx_zero))
		else $error("irq differs from summaries");
	a_one_cause: assert property ($rose(summary_irq_tx_one) |-> $past(|continuity_err_evt[3:0], 2) || $past(s_axi_bvalid))
		else $error("summary one rose without cause");
	a_drop_cause: assert property ($fell(summary_irq_tx_one) || $fell(summary_irq_tx_zero) |-> $past(s_axi_rvalid) || $past(s_axi_bvalid))
		else $error("summary fell without access");
endmodule : txp_irq_ctrl_props

bind txp_irq_ctrl txp_irq_ctrl_props txp_irq_ctrl_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .continuity_err_evt, .summary_irq_tx_one, .summary_irq_tx_zero, .irq);

`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, summary_irq_tx_one, summary_irq_tx_zero, irq;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, flush_err_evt;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  continuity_err_evt, header_err_evt;
	int          error_cnt, checks, cyc;
	int          rdy_hold;
	localparam logic [1:0] OK = txp_pkg::RESP_OKAY;

	txp_irq_ctrl txp_irq_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.continuity_err_evt, .header_err_evt, .flush_err_evt, .summary_irq_tx_one, .summary_irq_tx_zero, .irq);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// checks and bus access
	// ----------------------------------------------------------------
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected resp at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_resp

	// rdy_hold above zero raises bready or rready only after that many edges
	task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (rdy_hold == 0);
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (n == rdy_hold) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
		chk_resp(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
		#1;
	endtask : wr_chk

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (rdy_hold == 0);
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (n == rdy_hold) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
		chk_val(s_axi_rdata, ed);
		chk_resp(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
		#1;
	endtask : rd_chk

	// one-cycle event pulse, then wait until the summaries have settled
	task automatic pulse(input logic [19:0] v);
		@(posedge aclk);
		{continuity_err_evt, header_err_evt, flush_err_evt} <= v;
		@(posedge aclk);
		{continuity_err_evt, header_err_evt, flush_err_evt} <= 20'h00000;
		repeat (2) @(posedge aclk);
		#1;
	endtask : pulse

	// status bit to {continuity, header, flush} event lines
	function automatic logic [19:0] ev_map(input int i);
		logic [19:0] v;
		v = 20'h00000;
		if (i >= 16) v[31 - i] = 1'b1;
		else if (i >= 12) v[19 - i] = 1'b1;
		else if (i >= 8) v[11 - i] = 1'b1;
		else if (i >= 4) v[23 - i] = 1'b1;
		else v[11 - i] = 1'b1;
		return v;
	endfunction : ev_map

	function automatic logic [31:0] sum_now();
		return {29'h0, irq, summary_irq_tx_one, summary_irq_tx_zero};
	endfunction : sum_now

	task automatic close_out;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			error_cnt++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
		{continuity_err_evt, header_err_evt, flush_err_evt} = 20'h00000;
		{error_cnt, checks, cyc} = {32'h0, 32'h0, 32'h0};
		rdy_hold = 0;
		aresetn = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(txp_pkg::OFF_ENABLE, 32'h0, OK);
		rd_chk(txp_pkg::OFF_STATUS, 32'h0, OK);
		rd_chk(txp_pkg::OFF_SUMMARY, 32'h0, OK);
		rd_chk(12'h100, 32'h0, txp_pkg::RESP_SLVERR);
		wr_chk(12'h100, 32'hffffffff, 4'hf, txp_pkg::RESP_SLVERR);
		wr_chk(txp_pkg::OFF_ENABLE, 32'hffffffff, 4'hf, OK);
		rd_chk(txp_pkg::OFF_ENABLE, 32'h000fffff, OK);
		wr_chk(txp_pkg::OFF_ENABLE, 32'h0, 4'h1, OK);
		rd_chk(txp_pkg::OFF_ENABLE, 32'h000fff00, OK);
		$display("test registers done");
		rdy_hold = 3;
		wr_chk(txp_pkg::OFF_FLUSH_ALLOW, 32'h00000005, 4'hf, OK);
		rd_chk(txp_pkg::OFF_FLUSH_ALLOW, 32'h00000005, OK);
		rdy_hold = 0;
		$display("test slow answer done");
		wr_chk(txp_pkg::OFF_FLUSH_ALLOW, 32'h0, 4'hf, OK);
		pulse(20'h0000f);
		rd_chk(txp_pkg::OFF_STATUS, 32'h0, OK);
		$display("test flush gate done");
		wr_chk(txp_pkg::OFF_FLUSH_ALLOW, 32'h0000000f, 4'hf, OK);
		for (int i = 0; i < 20; i++) begin
			wr_chk(txp_pkg::OFF_ENABLE, 32'h1 << i, 4'hf, OK);
			pulse(ev_map(i));
			chk_val(sum_now(), (i >= 16) ? 32'h6 : 32'h5);
			rd_chk(txp_pkg::OFF_SUMMARY, (i >= 16) ? 32'h6 : 32'h5, OK);
			rd_chk(txp_pkg::OFF_STATUS, 32'h1 << i, OK);
			rd_chk(txp_pkg::OFF_STATUS, 32'h0, OK);
			chk_val(sum_now(), 32'h0);
			wr_chk(txp_pkg::OFF_ENABLE, 32'h000fffff ^ (32'h1 << i), 4'hf, OK);
			pulse(ev_map(i));
			chk_val(sum_now(), 32'h0);
			rd_chk(txp_pkg::OFF_STATUS, 32'h1 << i, OK);
		end
		$display("test routing done");
		wr_chk(txp_pkg::OFF_ENABLE, 32'h000fffff, 4'hf, OK);
		pulse(ev_map(19) | ev_map(15));
		chk_val(sum_now(), 32'h7);
		wr_chk(txp_pkg::OFF_STATUS, 32'h00080000, 4'hf, OK);
		chk_val(sum_now(), 32'h5);
		wr_chk(txp_pkg::OFF_SUMMARY, 32'hffffffff, 4'hf, OK);
		wr_chk(txp_pkg::OFF_STATUS, 32'h00008000, 4'h1, OK);
		rd_chk(txp_pkg::OFF_SUMMARY, 32'h5, OK);
		rd_chk(txp_pkg::OFF_STATUS, 32'h00008000, OK);
		chk_val(sum_now(), 32'h0);
		$display("test clear paths done");
		close_out();
	end
endmodule : tb

`default_nettype wire
